/* rtl/lmcd_pkg.sv */
package lmcd_pkg;
  localparam int CMD_W = 7;
  localparam int ADDR_W = 7;
  localparam int FT_W = 4;

  localparam logic [6:0] CMD_ACT_POS    = 7'h00;
  localparam logic [6:0] CMD_FULL_STAT  = 7'h01;
  localparam logic [6:0] CMD_FUSE_RD    = 7'h02;
  localparam logic [6:0] CMD_SHORT_STAT = 7'h03;
  localparam logic [6:0] CMD_SAFE_POS   = 7'h04;
  localparam logic [6:0] CMD_HALT       = 7'h05;
  localparam logic [6:0] CMD_ZERO_POS   = 7'h06;
  localparam logic [6:0] CMD_RAM_DEF    = 7'h07;
  localparam logic [6:0] CMD_TWO_MOVE   = 7'h08;
  localparam logic [6:0] CMD_LOAD_PARAM = 7'h09;
  localparam logic [6:0] CMD_FUSE_PROG  = 7'h10;
  localparam logic [6:0] CMD_MOVE       = 7'h0b;
  localparam logic [6:0] CMD_SHORT_1M   = 7'h0c;
  localparam logic [6:0] CMD_SHORT_2M   = 7'h0d;
  localparam logic [6:0] CMD_SHORT_4M   = 7'h0e;
  localparam logic [6:0] CMD_DEC_HALT   = 7'h0f;

  localparam logic [3:0] FT_W1 = 4'h1;
  localparam logic [3:0] FT_W2 = 4'h2;
  localparam logic [3:0] FT_W3 = 4'h3;
  localparam logic [3:0] FT_W4 = 4'h4;
  localparam logic [3:0] FT_R5 = 4'h5;
  localparam logic [3:0] FT_R6 = 4'h6;
  localparam logic [3:0] FT_P7 = 4'h7;
  localparam logic [3:0] FT_P8 = 4'h8;

  localparam int NUM_ACT = 14;
  localparam int A_SAFE = 0;
  localparam int A_HALT = 1;
  localparam int A_ZERO = 2;
  localparam int A_DEF  = 3;
  localparam int A_TWO  = 4;
  localparam int A_LOAD = 5;
  localparam int A_FUSE = 6;
  localparam int A_MOVE = 7;
  localparam int A_S1   = 8;
  localparam int A_S2   = 9;
  localparam int A_S4   = 10;
  localparam int A_SLP  = 11;
  localparam int A_DEC  = 12;
  localparam int A_GP   = 13;

  typedef enum logic [2:0] {
    LMCD_RSP_NONE  = 3'b000,
    LMCD_RSP_POS   = 3'b001,
    LMCD_RSP_FULL  = 3'b010,
    LMCD_RSP_FUSE  = 3'b011,
    LMCD_RSP_SHORT = 3'b100
  } lmcd_rsp_t;

  typedef enum logic [1:0] {
    LMCD_IDLE = 2'b00,
    LMCD_PREP = 2'b01
  } lmcd_state_t;
endpackage

/* rtl/lmcd_dec_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface lmcd_dec_if;
  logic [6:0] cmd;
  logic [3:0] ftype;
  logic       no_cmd;
  logic       valid;
  logic       known;
  logic [13:0] act;
  modport dec (input cmd, ftype, no_cmd, valid, output known, act);
  modport top (output cmd, ftype, no_cmd, valid, input known, act);
endinterface
`default_nettype wire

/* rtl/lmcd_cmd_table.sv */
`timescale 1ns/1ns
`default_nettype none
// combinational map of command code and frame type to a write action
module lmcd_cmd_table (
  lmcd_dec_if.dec d
);
  always_comb begin
    d.act = '0;
    d.known = 1'b0;
    if (d.valid) begin
      if (d.no_cmd) begin
        if (d.ftype == lmcd_pkg::FT_W1) begin
          d.act[lmcd_pkg::A_SLP] = 1'b1;
        end
      end else begin
        case (d.cmd)
          lmcd_pkg::CMD_SAFE_POS:
            d.act[lmcd_pkg::A_SAFE] = (d.ftype == lmcd_pkg::FT_W1);
          lmcd_pkg::CMD_HALT:
            d.act[lmcd_pkg::A_HALT] = (d.ftype == lmcd_pkg::FT_W1);
          lmcd_pkg::CMD_ZERO_POS:
            d.act[lmcd_pkg::A_ZERO] = (d.ftype == lmcd_pkg::FT_W1);
          lmcd_pkg::CMD_RAM_DEF:
            d.act[lmcd_pkg::A_DEF] = 1'b1;
          lmcd_pkg::CMD_TWO_MOVE:
            d.act[lmcd_pkg::A_TWO] = (d.ftype == lmcd_pkg::FT_W4);
          lmcd_pkg::CMD_LOAD_PARAM:
            d.act[lmcd_pkg::A_LOAD] = (d.ftype == lmcd_pkg::FT_W4);
          lmcd_pkg::CMD_FUSE_PROG:
            d.act[lmcd_pkg::A_FUSE] = 1'b1;
          lmcd_pkg::CMD_MOVE:
            d.act[lmcd_pkg::A_MOVE] = (d.ftype == lmcd_pkg::FT_W1) ||
                                      (d.ftype == lmcd_pkg::FT_W3) ||
                                      (d.ftype == lmcd_pkg::FT_W4);
          lmcd_pkg::CMD_SHORT_1M:
            d.act[lmcd_pkg::A_S1] = (d.ftype == lmcd_pkg::FT_W2);
          lmcd_pkg::CMD_SHORT_2M:
            d.act[lmcd_pkg::A_S2] = (d.ftype == lmcd_pkg::FT_W2);
          lmcd_pkg::CMD_SHORT_4M:
            d.act[lmcd_pkg::A_S4] = (d.ftype == lmcd_pkg::FT_W2);
          lmcd_pkg::CMD_DEC_HALT:
            d.act[lmcd_pkg::A_DEC] = (d.ftype == lmcd_pkg::FT_W1);
          default:
            d.act = '0;
        endcase
      end
      d.known = |d.act;
    end
  end
endmodule
`default_nettype wire

/* rtl/lmcd_decoder.sv */
// Operation
// - code 00 prep 7/8, read 5/6
// - code 01 prep 7/8, read 6
// - code 02 prep 7/8, read 6
// - code 03 read 5, no preparation
// - code 04 type 1: safe position
// - code 06 type 1: zero position
// - code 08 type 4: two-target move
// - code 09 type 4: load parameters
// - code 10: program one fuse byte
// - code 0B types 1,3,4: move
// - code 0C type 2: one motor, half-step
// - code 0D type 2: two motors, half-step
// - code 0E type 2: four motors, half-step
// - sleep: no code, type 1 frame
// - code 0F type 1: decelerating halt
// - broadcast bit low ignores address
// - general-purpose writes use dynamic identifiers
`timescale 1ns/1ns
`default_nettype none
module lmcd_decoder (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       frame_valid,
  input  wire logic [3:0] frame_type,
  input  wire logic       frame_no_cmd,
  input  wire logic       frame_dyn_id,
  input  wire logic       frame_has_bcast,
  input  wire logic       frame_bcast_n,
  input  wire logic [6:0] frame_cmd,
  input  wire logic [6:0] frame_addr,
  input  wire logic [6:0] node_addr,
  input  wire logic       half_step_mode,
  output logic            go_to_safe_position,
  output logic            immediate_halt,
  output logic            zero_actual_position,
  output logic            restore_ram_defaults,
  output logic            two_target_move,
  output logic            load_motion_parameters,
  output logic            program_fuse_byte,
  output logic            move_to_target,
  output logic            short_move_to_target,
  output logic [1:0]      short_motor_count,
  output logic            enter_sleep,
  output logic            decelerating_halt,
  output logic            general_write,
  output logic [2:0]      response_kind,
  output logic            response_valid,
  output logic            frame_ignored
);
  lmcd_dec_if dif ();

  lmcd_pkg::lmcd_state_t state_r, state_nxt;
  logic [2:0]  pend_r, pend_nxt;
  logic [13:0] act_r, act_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic [2:0]  rsp_r, rsp_nxt;
  logic        rspv_r, rspv_nxt;
  logic        ign_r, ign_nxt;
  logic        for_me;
  logic        is_prep, is_read, is_write;

  assign dif.cmd = frame_cmd;
  assign dif.ftype = frame_type;
  assign dif.no_cmd = frame_no_cmd;
  assign dif.valid = frame_valid && is_write && !frame_dyn_id;

  lmcd_cmd_table u_table (
    .d (dif)
  );

  // broadcast low: address not compared
  assign for_me = !frame_has_bcast || !frame_bcast_n || (frame_addr == node_addr);
  assign is_prep = (frame_type == lmcd_pkg::FT_P7) || (frame_type == lmcd_pkg::FT_P8);
  assign is_read = (frame_type == lmcd_pkg::FT_R5) || (frame_type == lmcd_pkg::FT_R6);
  assign is_write = (frame_type == lmcd_pkg::FT_W1) || (frame_type == lmcd_pkg::FT_W2) ||
                    (frame_type == lmcd_pkg::FT_W3) || (frame_type == lmcd_pkg::FT_W4);

  always_comb begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    act_nxt = '0;
    cnt_nxt = cnt_r;
    rsp_nxt = rsp_r;
    rspv_nxt = 1'b0;
    ign_nxt = 1'b0;
    if (frame_valid) begin
      if (is_prep) begin
        if (!for_me) begin
          state_nxt = lmcd_pkg::LMCD_IDLE;
        end else begin
          case (frame_cmd)
            lmcd_pkg::CMD_ACT_POS: begin
              state_nxt = lmcd_pkg::LMCD_PREP;
              pend_nxt = lmcd_pkg::LMCD_RSP_POS;
            end
            lmcd_pkg::CMD_FULL_STAT: begin
              state_nxt = lmcd_pkg::LMCD_PREP;
              pend_nxt = lmcd_pkg::LMCD_RSP_FULL;
            end
            lmcd_pkg::CMD_FUSE_RD: begin
              state_nxt = lmcd_pkg::LMCD_PREP;
              pend_nxt = lmcd_pkg::LMCD_RSP_FUSE;
            end
            default: begin
              state_nxt = lmcd_pkg::LMCD_IDLE;
              ign_nxt = 1'b1;
            end
          endcase
        end
      end else if (is_read) begin
        state_nxt = lmcd_pkg::LMCD_IDLE;
        if (frame_type == lmcd_pkg::FT_R6 && state_r == lmcd_pkg::LMCD_PREP) begin
          rsp_nxt = pend_r;
          rspv_nxt = 1'b1;
        end else if (frame_type == lmcd_pkg::FT_R5 && !frame_dyn_id &&
                     state_r == lmcd_pkg::LMCD_PREP && pend_r == lmcd_pkg::LMCD_RSP_POS) begin
          rsp_nxt = lmcd_pkg::LMCD_RSP_POS;
          rspv_nxt = 1'b1;
        end else if (frame_type == lmcd_pkg::FT_R5 && frame_dyn_id) begin
          // direct identifier read: command carried by the identifier
          if (frame_cmd == lmcd_pkg::CMD_SHORT_STAT) begin
            rsp_nxt = lmcd_pkg::LMCD_RSP_SHORT;
            rspv_nxt = 1'b1;
          end else if (frame_cmd == lmcd_pkg::CMD_ACT_POS) begin
            rsp_nxt = lmcd_pkg::LMCD_RSP_POS;
            rspv_nxt = 1'b1;
          end else begin
            ign_nxt = 1'b1;
          end
        end else begin
          ign_nxt = 1'b1;
        end
      end else if (is_write) begin
        state_nxt = lmcd_pkg::LMCD_IDLE;
        if (frame_dyn_id && (frame_type == lmcd_pkg::FT_W2 ||
                             frame_type == lmcd_pkg::FT_W4)) begin
          act_nxt[lmcd_pkg::A_GP] = 1'b1;
        end else if (frame_dyn_id) begin
          ign_nxt = 1'b1;
        end else if (!for_me || !dif.known) begin
          ign_nxt = 1'b1;
        end else if ((dif.act[lmcd_pkg::A_S1] || dif.act[lmcd_pkg::A_S2] ||
                      dif.act[lmcd_pkg::A_S4]) && !half_step_mode) begin
          ign_nxt = 1'b1;
        end else begin
          act_nxt = dif.act;
          if (dif.act[lmcd_pkg::A_S1]) begin
            cnt_nxt = 2'h0;
          end else if (dif.act[lmcd_pkg::A_S2]) begin
            cnt_nxt = 2'h1;
          end else if (dif.act[lmcd_pkg::A_S4]) begin
            cnt_nxt = 2'h2;
          end
        end
      end else begin
        ign_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= lmcd_pkg::LMCD_IDLE;
      pend_r <= lmcd_pkg::LMCD_RSP_NONE;
      act_r <= '0;
      cnt_r <= 2'h0;
      rsp_r <= lmcd_pkg::LMCD_RSP_NONE;
      rspv_r <= 1'b0;
      ign_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      act_r <= act_nxt;
      cnt_r <= cnt_nxt;
      rsp_r <= rsp_nxt;
      rspv_r <= rspv_nxt;
      ign_r <= ign_nxt;
    end
  end

  assign go_to_safe_position = act_r[lmcd_pkg::A_SAFE];
  assign immediate_halt = act_r[lmcd_pkg::A_HALT];
  assign zero_actual_position = act_r[lmcd_pkg::A_ZERO];
  assign restore_ram_defaults = act_r[lmcd_pkg::A_DEF];
  assign two_target_move = act_r[lmcd_pkg::A_TWO];
  assign load_motion_parameters = act_r[lmcd_pkg::A_LOAD];
  assign program_fuse_byte = act_r[lmcd_pkg::A_FUSE];
  assign move_to_target = act_r[lmcd_pkg::A_MOVE];
  assign short_move_to_target = act_r[lmcd_pkg::A_S1] | act_r[lmcd_pkg::A_S2] |
                                act_r[lmcd_pkg::A_S4];
  assign short_motor_count = cnt_r;
  assign enter_sleep = act_r[lmcd_pkg::A_SLP];
  assign decelerating_halt = act_r[lmcd_pkg::A_DEC];
  assign general_write = act_r[lmcd_pkg::A_GP];
  assign response_kind = rsp_r;
  assign response_valid = rspv_r;
  assign frame_ignored = ign_r;
endmodule
`default_nettype wire

/* tb/lmcd_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lmcd_master_model (
  input  wire logic        clk_sys,
  input  wire logic        send,
  input  wire logic [21:0] req,
  output logic             frame_valid,
  output logic [21:0]      fields
);
  logic [21:0] last_r;
  logic [21:0] last_nxt;
  always_comb last_nxt = send ? req : last_r;
  always_ff @(posedge clk_sys) last_r <= last_nxt;
  // released fields show the inverse, never a stale frame
  assign fields = send ? req : ~last_r;
  assign frame_valid = send;
endmodule
`default_nettype wire

/* tb/lmcd_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module lmcd_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       frame_valid,
  input wire logic [3:0] frame_type,
  input wire logic       frame_no_cmd,
  input wire logic       frame_dyn_id,
  input wire logic       frame_has_bcast,
  input wire logic       frame_bcast_n,
  input wire logic [6:0] frame_cmd,
  input wire logic [6:0] frame_addr,
  input wire logic [6:0] node_addr,
  input wire logic       half_step_mode,
  input wire logic       go_to_safe_position,
  input wire logic       two_target_move,
  input wire logic       short_move_to_target,
  input wire logic       decelerating_halt,
  input wire logic       general_write,
  input wire logic [2:0] response_kind,
  input wire logic       response_valid,
  input wire logic       frame_ignored
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic ok;
  logic wr;
  assign ok = !frame_has_bcast || !frame_bcast_n || frame_addr == node_addr;
  assign wr = frame_valid && !frame_no_cmd && !frame_dyn_id && ok;
  sequence prep_full;
    wr && frame_type inside {4'h7, 4'h8} && frame_cmd == 7'h01;
  endsequence
  sequence read_six;
    frame_valid && frame_type == 4'h6;
  endsequence
  a_soft_halt:
    assert property (wr && frame_type == 4'h1 && frame_cmd == 7'h0f |=> decelerating_halt)
      else $error("soft halt missing");
  a_addr_refused:
    assert property (frame_valid && frame_type == 4'h1 && !ok |=> frame_ignored)
      else $error("foreign address acted on");
  a_safe_pos:
    assert property (wr && frame_type == 4'h1 && frame_cmd == 7'h04 |=> go_to_safe_position)
      else $error("safe position missing");
  a_two_move:
    assert property (wr && frame_type == 4'h4 && frame_cmd == 7'h08 |=> two_target_move)
      else $error("two target move missing");
  a_short_half:
    assert property (short_move_to_target |-> $past(half_step_mode))
      else $error("short move outside half step");
  a_unknown_code:
    assert property (wr && frame_type < 4'h5 && frame_cmd > 7'h10 |=> frame_ignored)
      else $error("unknown code not ignored");
  a_gp_dyn:
    assert property (frame_valid && frame_dyn_id && frame_type inside {4'h2, 4'h4}
      |=> general_write) else $error("general write missing");
  a_short_status:
    assert property (frame_valid && frame_dyn_id && frame_type == 4'h5 && frame_cmd == 7'h03
      |=> response_valid && response_kind == 3'h4) else $error("short status missing");
  a_full_status:
    assert property (prep_full ##1 read_six |=> response_valid && response_kind == 3'h2)
      else $error("full status missing");
endmodule
bind lmcd_decoder lmcd_checker lmcd_checker_inst (.*);
`default_nettype wire

/* tb/lmcd_decoder_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module lmcd_decoder_bench;
  localparam logic [6:0] NODE = 7'h2a;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        send = 1'b0;
  logic        half = 1'b0;
  logic [21:0] req = '0;
  logic [21:0] fld;
  logic        fv;
  logic [11:0] act;
  logic [1:0]  cnt;
  logic [2:0]  kind;
  logic        rv;
  logic        ign;
  logic [2:0]  arm = '0;
  logic [2:0]  k_x = '0;
  logic [1:0]  c_x = '0;
  int          failures = 0;
  int          n_compared = 0;
  logic [21:0] hand [26] = '{
    {4'h7, 4'h3, 7'h01, NODE}, {4'h6, 4'h0, 7'h00, NODE},
    {4'h8, 4'h3, 7'h02, NODE}, {4'h6, 4'h0, 7'h00, NODE},
    {4'h7, 4'h0, 7'h00, NODE}, {4'h5, 4'h0, 7'h00, NODE},
    {4'h8, 4'h0, 7'h00, NODE}, {4'h6, 4'h0, 7'h00, NODE},
    {4'h5, 4'h4, 7'h03, NODE}, {4'h5, 4'h4, 7'h00, NODE},
    {4'h6, 4'h0, 7'h00, NODE}, {4'h7, 4'h3, 7'h01, 7'h55},
    {4'h6, 4'h0, 7'h00, NODE}, {4'h7, 4'h2, 7'h00, 7'h55},
    {4'h6, 4'h0, 7'h00, NODE}, {4'h8, 4'h0, 7'h01, NODE},
    {4'h1, 4'h0, 7'h0f, NODE}, {4'h6, 4'h0, 7'h00, NODE},
    {4'h3, 4'h4, 7'h0b, NODE}, {4'h1, 4'h8, 7'h00, NODE},
    {4'h7, 4'h0, 7'h05, NODE}, {4'h6, 4'h0, 7'h00, NODE},
    {4'h4, 4'h0, 7'h08, NODE}, {4'h4, 4'h2, 7'h09, 7'h55},
    {4'h2, 4'h4, 7'h00, NODE}, {4'h4, 4'h4, 7'h00, NODE}};
  always #50 clk_sys = ~clk_sys;
  lmcd_master_model lmcd_master_model_inst (.clk_sys(clk_sys), .send(send), .req(req),
    .frame_valid(fv), .fields(fld));
  lmcd_decoder lmcd_decoder_inst (.clk_sys(clk_sys), .rst(rst), .frame_valid(fv),
    .frame_type(fld[21:18]), .frame_no_cmd(fld[17]), .frame_dyn_id(fld[16]),
    .frame_has_bcast(fld[15]), .frame_bcast_n(fld[14]), .frame_cmd(fld[13:7]),
    .frame_addr(fld[6:0]), .node_addr(NODE), .half_step_mode(half),
    .go_to_safe_position(act[11]), .immediate_halt(act[10]), .zero_actual_position(act[9]),
    .restore_ram_defaults(act[8]), .two_target_move(act[7]), .load_motion_parameters(act[6]),
    .program_fuse_byte(act[5]), .move_to_target(act[4]), .short_move_to_target(act[3]),
    .short_motor_count(cnt), .enter_sleep(act[2]), .decelerating_halt(act[1]),
    .general_write(act[0]), .response_kind(kind), .response_valid(rv), .frame_ignored(ign));
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [18:0] e, input logic [18:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic frame(input logic v, input logic [21:0] r);
    logic [11:0] a;
    logic [3:0]  t;
    logic [6:0]  cd;
    logic        ok;
    logic        rd;
    logic        hs;
    logic        ie;
    a = '0;
    rd = 1'b0;
    t = r[21:18];
    cd = r[13:7];
    hs = $urandom_range(0, 1) != 0;
    ok = !r[15] || !r[14] || r[6:0] == NODE;
    if (v && t > 4'h6) arm = (ok && cd < 7'h03) ? {1'b1, cd[1:0]} : 3'h0;
    else if (v) begin
      if (t == 4'h6 && arm[2] || t == 4'h5 && (r[16] || arm == 3'h4)) begin
        rd = 1'b1;
        k_x = r[16] ? (cd == 7'h03 ? 3'h4 : 3'h1) : {1'b0, arm[1:0]} + 3'h1;
      end else if (t < 4'h5 && r[16]) a[0] = !t[0];
      else if (t < 4'h5 && ok) begin
        a[2] = r[17] && t == 4'h1;
        a[11] = !r[17] && t == 4'h1 && cd == 7'h04;
        a[10] = !r[17] && t == 4'h1 && cd == 7'h05;
        a[9] = !r[17] && t == 4'h1 && cd == 7'h06;
        a[8] = !r[17] && cd == 7'h07;
        a[7] = !r[17] && t == 4'h4 && cd == 7'h08;
        a[6] = !r[17] && t == 4'h4 && cd == 7'h09;
        a[5] = !r[17] && cd == 7'h10;
        a[4] = !r[17] && t != 4'h2 && cd == 7'h0b;
        a[3] = !r[17] && t == 4'h2 && hs && cd inside {7'h0c, 7'h0d, 7'h0e};
        a[1] = !r[17] && t == 4'h1 && cd == 7'h0f;
        if (a[3]) c_x = cd[1:0] ^ 2'h0;
      end
      arm = 3'h0;
    end
    // prep for this node with a code outside 00..02 is refused too
    ie = v && (t < 4'h7 ? !rd && a == '0 : ok && cd > 7'h02);
    half = hs;
    send = v;
    req = r;
    @(posedge clk_sys);
    #1;
    cmp("outputs", {a, c_x, ie, rd, k_x}, {act, cnt, ign, rv, kind});
  endtask
  initial begin
    #1000000;
    failures++;
    results();
  end
  initial begin
    logic [31:0] rnd;
    void'($urandom(32'h954ea40b));
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    frame(1'b0, '0);
    for (int i = 0; i < 500; i++) begin
      rnd = $urandom;
      frame(rnd[31:30] != 2'h0, {1'b0, {1'b0, rnd[1:0]} + 3'h1, rnd[2] && !rnd[3],
        rnd[3:0] == 4'h8, rnd[11:10], rnd[9] ? {3'h0, rnd[7:4]} : {2'h0, rnd[8:4]},
        rnd[12] ? NODE : rnd[19:13]});
    end
    foreach (hand[i]) frame(1'b1, hand[i]);
    frame(1'b0, '0);
    results();
  end
endmodule
`default_nettype wire
